// ==== core/rscfg_top.sv ====
// Purpose: latch board straps at reset, steer host data pins, hold config regs
// Assumes: rst_n is the device reset; straps are stable while it is low
// Notes: outputs are registered; pin steering lags the peripherals by a cycle
`timescale 1ns/1ns

// How it works
// - address, byte-order, host-width and network straps are captured on the first clock after reset release.
// - byte-order strap 0 gives big-endian, 1 gives little-endian, the default.
// - boot strap: 00 none, 01 host port, 10 reserved, 11 8-bit ROM.
// - memory clock strap: 00 clock pin, 01 cpu/4, 10 cpu/6, 11 reserved.
// - host-width 0 uses low sixteen data pins, upper float; 1 uses all 32.
// - network strap 0 disables mac; host width follows its strap.
// - network 1, width 0: 16-bit host low, upper sixteen go to mac.
// - both straps 1: host port off, low pins float, upper sixteen to mac.
// - config registers live in a 4K window at 0x01B3F000 on config bus.
// - after reset software selects video ports, serial ports and i2c.
// - timers and gpio always present; i2c, serial 0, video 2 have select bits; host/mac share.
module rscfg_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // strap pins
  input wire logic [3:0] ext_addr_strap_pins,
  input wire logic byte_order_strap,
  input wire logic host_width_strap,
  input wire logic net_select_strap,
  input wire logic general_io_bit0,
  // config bus
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [31:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // latched configuration
  output logic endian_mode,
  output logic [1:0] boot_mode,
  output logic [1:0] ext_mem_clock_select,
  output logic host_port_width,
  output logic host_port_en,
  output logic ethernet_net_select_strap,
  output logic config_invalid,
  // peripheral selects
  output logic [rscfg_pkg::RSCFG_PSEL_W-1:0] periph_sel,
  // host data pins
  input wire logic [31:0] host_data_pins_in,
  output logic [31:0] host_data_pins_out,
  output logic [31:0] host_data_pins_oe,
  // peripheral side of the data pins
  input wire logic [31:0] host_port_dout,
  input wire logic [31:0] host_port_doe,
  output logic [31:0] host_port_din,
  input wire logic [15:0] ethernet_mac_dout,
  input wire logic [15:0] ethernet_mac_doe,
  output logic [15:0] ethernet_mac_din
);
  import rscfg_pkg::*;

  typedef struct packed {
    logic cap_done;
    logic endian;
    logic [1:0] boot;
    logic [1:0] eclk;
    logic width;
    logic net;
    logic gp0_bad;
    logic hp_en;
    logic [6:0] psel;
    logic ack;
    logic [31:0] rdata;
    logic [31:0] hd_out;
    logic [31:0] hd_oe;
    logic [31:0] hp_din;
    logic [15:0] mac_din;
  } rscfg_st_t;

  rscfg_st_t st_q;
  rscfg_st_t st_d;
  logic [RSCFG_SY_W-1:0] strap_s;
  logic [31:0] hd_in_s;
  logic in_win;
  logic [31:0] stat_word;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  rscfg_sync #(.W(RSCFG_SY_W)) u_strap_sync (
    .clk_sys(clk_sys),
    .d({general_io_bit0, net_select_strap, host_width_strap, byte_order_strap,
        ext_addr_strap_pins}),
    .q(strap_s)
  );

  rscfg_sync #(.W(32)) u_data_sync (
    .clk_sys(clk_sys),
    .d(host_data_pins_in),
    .q(hd_in_s)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    // only the page bits decide the window
    in_win = (cfg_addr[31:RSCFG_WIN_BITS] == RSCFG_WIN_BASE[31:RSCFG_WIN_BITS]);
    st_d = st_q;
    // sync flops carry reset-time pin levels into the first cycle after release
    if (!st_q.cap_done)
    begin
      st_d.cap_done = 1'b1;
      st_d.endian = strap_s[RSCFG_SY_ENDIAN];
      st_d.boot = strap_s[RSCFG_SY_BOOT +: 2];
      st_d.eclk = strap_s[RSCFG_SY_ECLK +: 2];
      st_d.width = strap_s[RSCFG_SY_WIDTH];
      st_d.net = strap_s[RSCFG_SY_NET];
      st_d.gp0_bad = strap_s[RSCFG_SY_GP0];
    end
    // once captured, nothing but reset touches the straps
    // built from the next state so a read on the capture edge sees the straps
    stat_word = 32'h00000000;
    stat_word[RSCFG_ST_ENDIAN] = st_d.endian;
    stat_word[RSCFG_ST_BOOT +: 2] = st_d.boot;
    stat_word[RSCFG_ST_ECLK +: 2] = st_d.eclk;
    stat_word[RSCFG_ST_WIDTH] = st_d.width;
    stat_word[RSCFG_ST_NET] = st_d.net;
    stat_word[RSCFG_ST_GP0BAD] = st_d.gp0_bad;
    st_d.hp_en = st_d.cap_done && !(st_d.width && st_d.net);
    st_d.ack = cfg_req && in_win;
    st_d.rdata = 32'h00000000;
    if (cfg_req && in_win && !cfg_wr)
    begin
      case (cfg_addr)
        RSCFG_PSEL_ADDR: st_d.rdata = {25'h0000000, st_q.psel};
        RSCFG_STAT_ADDR: st_d.rdata = stat_word;
        RSCFG_SCAN_ADDR: st_d.rdata = RSCFG_SCAN_ID;
        default: st_d.rdata = 32'h00000000;
      endcase
    end
    if (cfg_req && in_win && cfg_wr && cfg_addr == RSCFG_PSEL_ADDR)
    begin
      // reserved bit 4 keeps its zero
      st_d.psel = (st_q.psel & ~RSCFG_PSEL_WMASK)
                | (cfg_wdata[RSCFG_PSEL_W-1:0] & RSCFG_PSEL_WMASK);
    end
    // only host port and mac share pins; others are never muxed here
    st_d.hd_out = host_port_dout;
    st_d.hd_oe = host_port_doe;
    st_d.hp_din = hd_in_s;
    st_d.mac_din = 16'h0000;
    case ({st_q.width, st_q.net})
      2'b00:
      begin
        st_d.hd_oe[31:16] = 16'h0000;
        st_d.hp_din[31:16] = 16'h0000;
      end
      2'b01:
      begin
        st_d.hd_out[31:16] = ethernet_mac_dout;
        st_d.hd_oe[31:16] = ethernet_mac_doe;
        st_d.hp_din[31:16] = 16'h0000;
        st_d.mac_din = hd_in_s[31:16];
      end
      2'b10:
      begin
        st_d.hd_oe = host_port_doe;
      end
      2'b11:
      begin
        st_d.hd_out = {ethernet_mac_dout, 16'h0000};
        st_d.hd_oe = {ethernet_mac_doe, 16'h0000};
        st_d.hp_din = 32'h00000000;
        st_d.mac_din = hd_in_s[31:16];
      end
      default:
      begin
        st_d.hd_oe = 32'h00000000;
      end
    endcase
    // no drive until the straps are known, avoids fighting the resistors
    if (!st_q.cap_done)
    begin
      st_d.hd_oe = 32'h00000000;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '0;
      st_q.endian <= 1'b1;
      st_q.psel <= RSCFG_PSEL_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign cfg_ack = st_q.ack;
  assign cfg_rdata = st_q.rdata;
  assign endian_mode = st_q.endian;
  assign boot_mode = st_q.boot;
  assign ext_mem_clock_select = st_q.eclk;
  assign host_port_width = st_q.width;
  assign host_port_en = st_q.hp_en;
  assign ethernet_net_select_strap = st_q.net;
  assign config_invalid = st_q.gp0_bad;
  assign periph_sel = st_q.psel;
  assign host_data_pins_out = st_q.hd_out;
  assign host_data_pins_oe = st_q.hd_oe;
  assign host_port_din = st_q.hp_din;
  assign ethernet_mac_din = st_q.mac_din;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_rd_stat;
    cfg_req && !cfg_wr && cfg_addr == RSCFG_STAT_ADDR;
  endsequence

  sequence s_wr_psel;
    cfg_req && cfg_wr && cfg_addr == RSCFG_PSEL_ADDR;
  endsequence

  chk_strap_capture: assert property ($rose(st_q.cap_done) |->
    endian_mode == $past(strap_s[RSCFG_SY_ENDIAN])
    && host_port_width == $past(strap_s[RSCFG_SY_WIDTH])
    && boot_mode == $past(strap_s[RSCFG_SY_BOOT +: 2]))
    else $error("strap values not captured at reset release");

  chk_strap_hold: assert property (st_q.cap_done |=>
    $stable(endian_mode) && $stable(boot_mode) && $stable(ext_mem_clock_select)
    && $stable(host_port_width) && $stable(ethernet_net_select_strap))
    else $error("captured straps changed after release");

  chk_status_read: assert property (s_rd_stat |=> cfg_ack
    && cfg_rdata[RSCFG_ST_ENDIAN] == endian_mode
    && cfg_rdata[RSCFG_ST_ECLK +: 2] == ext_mem_clock_select)
    else $error("status word does not show latched straps");

  chk_out_window: assert property (cfg_req && cfg_addr[31:12] != 20'h01B3F |=> !cfg_ack)
    else $error("answer given outside config window");

  chk_psel_write: assert property (s_wr_psel ##0 (cfg_addr[31:12] == 20'h01B3F) |=>
    cfg_ack && periph_sel == ($past(cfg_wdata[6:0]) & 7'h6F))
    else $error("peripheral select write not applied");

  chk_width16_float: assert property (st_q.cap_done && !host_port_width && !ethernet_net_select_strap
    |=> host_data_pins_oe[31:16] == 16'h0000)
    else $error("upper data pins driven in 16-bit mode");

  chk_mac_upper: assert property (st_q.cap_done && ethernet_net_select_strap && !host_port_width
    |=> host_data_pins_oe[31:16] == $past(ethernet_mac_doe) && host_port_en)
    else $error("upper pins not given to mac");

  chk_host_off: assert property (st_q.cap_done && ethernet_net_select_strap && host_port_width
    |=> host_data_pins_oe[15:0] == 16'h0000 && !host_port_en)
    else $error("low pins driven with host port off");

  chk_mac_off: assert property (!ethernet_net_select_strap |-> ethernet_mac_din == 16'h0000)
    else $error("mac sees data while disabled");
endmodule

// ==== core/rscfg_pkg.sv ====
// Purpose: constants for the reset strap capture and pin select block
// Assumes: 125 MHz clk_sys, strap pins sampled through two flops
// Notes: status and identity word layouts are local to this block
package rscfg_pkg;
  // config window and register addresses
  localparam logic [31:0] RSCFG_WIN_BASE = 32'h01B3F000;
  localparam int RSCFG_WIN_BITS = 12;
  localparam logic [31:0] RSCFG_PSEL_ADDR = 32'h01B3F000;
  localparam logic [31:0] RSCFG_STAT_ADDR = 32'h01B3F004;
  localparam logic [31:0] RSCFG_SCAN_ADDR = 32'h01B3F008;
  // value is arbitrary
  localparam logic [31:0] RSCFG_SCAN_ID = 32'h0A5A5001;

  // peripheral_select_control fields
  localparam int RSCFG_PSEL_W = 7;
  localparam int RSCFG_PSEL_AUD0 = 0;
  localparam int RSCFG_PSEL_BSP0 = 1;
  localparam int RSCFG_PSEL_COMPAT = 2;
  localparam int RSCFG_PSEL_I2C0 = 3;
  localparam int RSCFG_PSEL_VP1 = 5;
  localparam int RSCFG_PSEL_VP2 = 6;
  localparam logic [6:0] RSCFG_PSEL_RST = 7'h06;
  localparam logic [6:0] RSCFG_PSEL_WMASK = 7'h6F;

  // device_status_reg fields
  localparam int RSCFG_ST_ENDIAN = 0;
  localparam int RSCFG_ST_BOOT = 1;
  localparam int RSCFG_ST_ECLK = 3;
  localparam int RSCFG_ST_WIDTH = 5;
  localparam int RSCFG_ST_NET = 6;
  localparam int RSCFG_ST_GP0BAD = 7;

  // strap encodings
  localparam logic [1:0] RSCFG_BOOT_NONE = 2'h0;
  localparam logic [1:0] RSCFG_BOOT_HOST = 2'h1;
  localparam logic [1:0] RSCFG_BOOT_ROM8 = 2'h3;
  localparam logic [1:0] RSCFG_ECLK_PIN = 2'h0;
  localparam logic [1:0] RSCFG_ECLK_DIV4 = 2'h1;
  localparam logic [1:0] RSCFG_ECLK_DIV6 = 2'h2;
  localparam logic RSCFG_BIG_ENDIAN = 1'b0;

  // strap synchroniser bit positions
  localparam int RSCFG_SY_W = 8;
  localparam int RSCFG_SY_ECLK = 0;
  localparam int RSCFG_SY_BOOT = 2;
  localparam int RSCFG_SY_ENDIAN = 4;
  localparam int RSCFG_SY_WIDTH = 5;
  localparam int RSCFG_SY_NET = 6;
  localparam int RSCFG_SY_GP0 = 7;
endpackage

// ==== core/rscfg_sync.sv ====
// Purpose: two-flop level synchroniser, one bit per lane
// Assumes: inputs are quasi-static levels from pins
// Notes: no reset, so the flops track the pins while device reset is low
`timescale 1ns/1ns
module rscfg_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic clk_sys,
  // lanes
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys)
  begin
    meta <= d;
    q <= meta;
  end
endmodule

// ==== testbench/rscfg_board.sv ====
// Purpose: board strap resistors, later the shared pins in normal use
// Assumes: cfg bits [3:0] addr, [4] byte order, [5] width, [6] net, [7] gpio0
// Notes: pins toggle every cycle after reset so late activity is visible
`timescale 1ns/1ns
module rscfg_board (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // commanded strap set
  input wire logic [7:0] cfg,
  // strap pins
  output logic [3:0] ext_addr_strap_pins,
  output logic byte_order_strap,
  output logic host_width_strap,
  output logic net_select_strap,
  output logic general_io_bit0
);
  logic [7:0] pin_q;
  // gpio0 holds cfg[7] during reset, then toggles every cycle like the other pins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pin_q <= cfg;
    else
      pin_q <= ~pin_q;
  end
  assign {general_io_bit0, net_select_strap, host_width_strap} = pin_q[7:5];
  assign {byte_order_strap, ext_addr_strap_pins} = pin_q[4:0];
endmodule

// ==== testbench/rscfg_top_tb.sv ====
// Purpose: self-checking bench for strap capture, pin steering and config regs
// Assumes: stimulus on falling edge, 8 ns clock
// Notes: status word layout follows the design's package
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module rscfg_top_tb;
  import rscfg_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] bcfg = 8'h10;
  logic [3:0] ea;
  logic bo, hw, ns, g0;
  logic cfg_req = 1'b0, cfg_wr = 1'b0, cfg_ack;
  logic [31:0] cfg_addr = '0, cfg_wdata = '0, cfg_rdata;
  logic endian_mode, host_port_width, host_port_en, ethernet_net_select_strap, config_invalid;
  logic [1:0] boot_mode, ext_mem_clock_select;
  logic [6:0] periph_sel;
  logic [31:0] pin_in = 32'hC3C39696, pin_out, pin_oe, hp_do = 32'h1234ABCD, hp_oe = '1, hp_di;
  logic [15:0] mac_do = 16'h5A5A, mac_oe = '1, mac_di;
  int err_total = 0, cmp_count = 0;
  logic [7:0] tbl [6] = '{8'h10, 8'h05, 8'h5A, 8'h2F, 8'h77, 8'h84};
  always #4 clk_sys = ~clk_sys;
  rscfg_board u_board (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(bcfg),
    .ext_addr_strap_pins(ea), .byte_order_strap(bo), .host_width_strap(hw),
    .net_select_strap(ns), .general_io_bit0(g0));
  rscfg_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ext_addr_strap_pins(ea),
    .byte_order_strap(bo), .host_width_strap(hw), .net_select_strap(ns),
    .general_io_bit0(g0), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .endian_mode(endian_mode), .boot_mode(boot_mode),
    .ext_mem_clock_select(ext_mem_clock_select), .host_port_width(host_port_width),
    .host_port_en(host_port_en), .ethernet_net_select_strap(ethernet_net_select_strap),
    .config_invalid(config_invalid), .periph_sel(periph_sel),
    .host_data_pins_in(pin_in), .host_data_pins_out(pin_out), .host_data_pins_oe(pin_oe),
    .host_port_dout(hp_do), .host_port_doe(hp_oe), .host_port_din(hp_di),
    .ethernet_mac_dout(mac_do), .ethernet_mac_doe(mac_oe), .ethernet_mac_din(mac_di));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one-cycle request, answer sampled in the cycle after the taking edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
    output logic ack, output logic [31:0] rd);
    @(negedge clk_sys);
    cfg_req = 1'b1;
    cfg_wr = wr;
    cfg_addr = a;
    cfg_wdata = wd;
    @(negedge clk_sys);
    cfg_req = 1'b0;
    ack = cfg_ack;
    rd = cfg_rdata;
  endtask
  task automatic t_reset(input logic [7:0] c);
    @(negedge clk_sys);
    bcfg = c;
    rst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
  endtask
  // captured straps, then again after the pins have toggled for a while
  task automatic t_capture(input logic [7:0] c);
    logic ack;
    logic [31:0] rd;
    bus(1'b0, RSCFG_STAT_ADDR, '0, ack, rd);
    `CHK("status", ({24'h0, c[7:5], c[1:0], c[3:2], c[4]}), rd)
    `CHK("stat_ack", 1'b1, ack)
    repeat (20) @(negedge clk_sys);
    bus(1'b0, RSCFG_STAT_ADDR, '0, ack, rd);
    `CHK("status_late", ({24'h0, c[7:5], c[1:0], c[3:2], c[4]}), rd)
    `CHK("endian", c[4], endian_mode)
    `CHK("boot", c[3:2], boot_mode)
    `CHK("eclk", c[1:0], ext_mem_clock_select)
    `CHK("width", c[5], host_port_width)
    `CHK("net_select_strap", c[6], ethernet_net_select_strap)
    `CHK("host_en", !(c[5] && c[6]), host_port_en)
    `CHK("invalid", c[7], config_invalid)
  endtask
  task automatic t_mux(input logic w, input logic n);
    logic [15:0] lo, hi;
    lo = (w && n) ? 16'h0000 : 16'hFFFF;
    hi = (w || n) ? 16'hFFFF : 16'h0000;
    `CHK("oe", ({hi, lo}), pin_oe)
    `CHK("out", ({hi & (n ? mac_do : hp_do[31:16]), lo & hp_do[15:0]}), (pin_out & pin_oe))
    `CHK("hp_din", ({(w && !n) ? pin_in[31:16] : 16'h0, lo & pin_in[15:0]}), hp_di)
    `CHK("mac_din", n ? pin_in[31:16] : 16'h0000, mac_di)
  endtask
  task automatic t_regs;
    logic ack;
    logic [31:0] rd;
    bus(1'b0, RSCFG_PSEL_ADDR, '0, ack, rd);
    `CHK("psel_rst", {25'h0, RSCFG_PSEL_RST}, rd)
    bus(1'b1, RSCFG_PSEL_ADDR, 32'hFFFFFFFF, ack, rd);
    `CHK("psel_pin", RSCFG_PSEL_WMASK, periph_sel)
    bus(1'b1, RSCFG_STAT_ADDR, '0, ack, rd);
    bus(1'b0, RSCFG_PSEL_ADDR, '0, ack, rd);
    `CHK("psel_rd", {25'h0, RSCFG_PSEL_WMASK}, rd)
    bus(1'b0, RSCFG_SCAN_ADDR, '0, ack, rd);
    `CHK("scan", RSCFG_SCAN_ID, rd)
    bus(1'b0, RSCFG_WIN_BASE + 32'h00000FFC, '0, ack, rd);
    `CHK("hole", 33'h100000000, ({ack, rd}))
    bus(1'b0, RSCFG_WIN_BASE + 32'h00001000, '0, ack, rd);
    `CHK("outside", 1'b0, ack)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial
  begin
    foreach (tbl[i])
    begin
      t_reset(tbl[i]);
      t_mux(tbl[i][5], tbl[i][6]);
      t_capture(tbl[i]);
    end
    t_regs();
    end_sim();
  end
endmodule
